// [verilog/dc_loop_trim_pkg.sv]
package dc_loop_trim_pkg;

  // Command codes of the four registers
  localparam logic [7:0] ADDR_SENSE_OFFSET  = 8'h2d;
  localparam logic [7:0] ADDR_FB_GAIN       = 8'h2e;
  localparam logic [7:0] ADDR_CUR_GAIN      = 8'h2f;
  localparam logic [7:0] ADDR_HOLD_CTRL     = 8'h30;

  // Writable bit masks; everything else is dropped and reads as zero
  localparam logic [15:0] MASK_SENSE_OFFSET = 16'h007f;
  localparam logic [15:0] MASK_GAIN         = 16'h07ff;
  localparam logic [15:0] MASK_HOLD_CTRL    = 16'hffff;

  // Reset values
  localparam logic [15:0] RST_SENSE_OFFSET  = 16'h0000;
  localparam logic [15:0] RST_GAIN          = 16'h0400;
  localparam logic [15:0] RST_HOLD_CTRL     = 16'h0000;

  // Field layout
  localparam int OFFSET_W        = 7;
  localparam int OFFSET_SIGN_BIT = 6;
  localparam int GAIN_W          = 11;
  localparam int GAIN_FRAC       = 10;
  localparam int FREQ_IDLE_BIT   = 15;
  localparam int UV_IDLE_BIT     = 14;
  localparam int PRD_THR_MSB     = 13;
  localparam int PRD_THR_LSB     = 7;
  localparam int PRD_THR_W       = 7;
  localparam int PRD_HOLD_BIT    = 6;
  localparam int PHASE_HOLD_BIT  = 5;
  localparam int EXC_HOLD_BIT    = 4;
  localparam int HOLD_LEN_MSB    = 3;
  localparam int HOLD_LEN_LSB    = 0;
  localparam int HOLD_LEN_W      = 4;

  // Offset weights in microvolts per step
  localparam int OFFSET_STEP_UNITY_UV = 500;
  localparam int OFFSET_STEP_HALF_UV  = 800;

  // Feedback compare window; feedback and reference use FB_LSB_UV per count
  localparam int FB_LSB_UV       = 250;
  localparam int UNDER_MV        = 25;
  localparam int OVER_MV         = 20;
  localparam int UNDER_COUNT     = (UNDER_MV * 1000) / FB_LSB_UV;
  localparam int OVER_COUNT      = (OVER_MV * 1000) / FB_LSB_UV;

  // Period threshold step, periods are given in ns
  localparam int PRD_STEP_NS     = 80;

  // Hold timing
  localparam int CLOCK_HZ        = 20_000_000;
  localparam int HOLD_STEP_US    = 100;
  localparam int HOLD_STEP_CYCLES = (HOLD_STEP_US * (CLOCK_HZ / 1_000_000));

endpackage

// [verilog/sample_gain_scaler.sv]
`timescale 1ns/10ps
module sample_gain_scaler #(
  parameter int RAW_W  = 12,
  parameter int GAIN_W = 11,
  parameter int FRAC   = 10
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic [RAW_W-1:0]  raw,
  input  wire logic [GAIN_W-1:0] gain,
  output logic      [RAW_W:0]    scaled
);

  if (GAIN_W - FRAC != 1) begin : g_bad_frac
    $error("sample_gain_scaler: GAIN_W must be FRAC+1");
  end

  wire [RAW_W+GAIN_W-1:0] product = raw * gain;
  wire [RAW_W:0]          quotient = product[RAW_W+GAIN_W-1:FRAC];

  // Truncation toward zero; gain 1024 passes the sample unchanged
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      scaled <= '0;
    end else begin
      scaled <= quotient;
    end
  end

endmodule // sample_gain_scaler

// [verilog/dc_loop_trim_and_hold_ctrl.sv]
`timescale 1ns/10ps
module dc_loop_trim_and_hold_ctrl #(
  parameter int ADC_W    = 12,
  parameter int VOLT_W   = 16,
  parameter int PERIOD_W = 16,
  parameter int PHASE_W  = 3,
  parameter int SENSE_W  = 22
) (
  input  wire logic                clock,
  input  wire logic                arst_n,
  // Register access
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire logic [15:0]         reg_wdata,
  output logic      [15:0]         reg_rdata,
  // Sense path
  input  wire logic                sense_amp_gain_select,
  input  wire logic [SENSE_W-1:0]  sensed_output_uv,
  output logic      [SENSE_W-1:0]  sense_corrected_uv,
  output logic signed [17:0]       sense_offset_uv,
  input  wire logic [ADC_W-1:0]    feedback_raw_sample,
  input  wire logic [ADC_W-1:0]    current_raw_sample,
  output logic      [ADC_W:0]      feedback_scaled_sample,
  output logic      [ADC_W:0]      current_scaled_sample,
  // Phase adding
  input  wire logic                auto_shed_mode,
  input  wire logic                freq_over_limit,
  input  wire logic [VOLT_W-1:0]   feedback_voltage,
  input  wire logic [VOLT_W-1:0]   output_reference,
  output logic                     full_phase_ccm,
  output logic                     idle_phase_level,
  // Hold logic
  input  wire logic [PERIOD_W-1:0] measured_period_ns,
  input  wire logic [PERIOD_W-1:0] configured_period_ns,
  input  wire logic                period_hold_qualify,
  input  wire logic [PHASE_W-1:0]  active_phase_count,
  output logic                     period_error,
  output logic                     voltage_loop_hold
);

  // Widths the arithmetic below cannot serve are refused at elaboration
  if (ADC_W < 4 || ADC_W > 20) begin : g_bad_adc_w
    $error("ADC_W out of range");
  end
  if (VOLT_W < 10 || VOLT_W > 24) begin : g_bad_volt_w
    $error("VOLT_W out of range");
  end
  if (PERIOD_W < 15 || PERIOD_W > 24) begin : g_bad_period_w
    $error("PERIOD_W out of range");
  end
  if (SENSE_W < 18 || SENSE_W > 30) begin : g_bad_sense_w
    $error("SENSE_W out of range");
  end
  if (PHASE_W < 1) begin : g_bad_phase_w
    $error("PHASE_W out of range");
  end

  localparam int HDIV_W = $clog2(dc_loop_trim_pkg::HOLD_STEP_CYCLES);
  localparam logic [HDIV_W-1:0] HDIV_LAST = HDIV_W'(dc_loop_trim_pkg::HOLD_STEP_CYCLES - 1);
  localparam logic signed [VOLT_W:0] UNDER_LIM = (VOLT_W+1)'(dc_loop_trim_pkg::UNDER_COUNT);
  localparam logic signed [VOLT_W:0] OVER_LIM  = (VOLT_W+1)'(dc_loop_trim_pkg::OVER_COUNT);
  localparam logic [PERIOD_W:0] PRD_STEP = (PERIOD_W+1)'(dc_loop_trim_pkg::PRD_STEP_NS);
  localparam logic [4:0] STEP_UNITY = 5'(dc_loop_trim_pkg::OFFSET_STEP_UNITY_UV / 100);
  localparam logic [4:0] STEP_HALF  = 5'(dc_loop_trim_pkg::OFFSET_STEP_HALF_UV / 100);

  typedef enum logic [1:0] {
    HOLD_IDLE   = 2'b01,
    HOLD_FROZEN = 2'b10
  } hold_state_t;

  // Merge a write into a register, keeping only implemented bits
  function automatic logic [15:0] masked(input logic [15:0] data, input logic [15:0] mask);
    masked = data & mask;
  endfunction

  // Unsigned distance between two periods
  function automatic logic [PERIOD_W:0] distance(input logic [PERIOD_W-1:0] a, input logic [PERIOD_W-1:0] b);
    distance = (a >= b) ? {1'b0, a - b} : {1'b0, b - a};
  endfunction

  // Registers
  logic [15:0] sense_amp_offset_q;
  logic [15:0] feedback_digital_gain_q;
  logic [15:0] current_monitor_digital_gain_q;
  logic [15:0] voltage_loop_hold_control_q;

  wire wr_offset = reg_wr && (reg_addr == dc_loop_trim_pkg::ADDR_SENSE_OFFSET);
  wire wr_fbgain = reg_wr && (reg_addr == dc_loop_trim_pkg::ADDR_FB_GAIN);
  wire wr_cugain = reg_wr && (reg_addr == dc_loop_trim_pkg::ADDR_CUR_GAIN);
  wire wr_ctrl   = reg_wr && (reg_addr == dc_loop_trim_pkg::ADDR_HOLD_CTRL);

  // Next values; a write keeps only the implemented bits
  wire [15:0] sense_amp_offset_d = wr_offset ?
    masked(reg_wdata, dc_loop_trim_pkg::MASK_SENSE_OFFSET) : sense_amp_offset_q;
  wire [15:0] feedback_digital_gain_d = wr_fbgain ?
    masked(reg_wdata, dc_loop_trim_pkg::MASK_GAIN) : feedback_digital_gain_q;
  wire [15:0] current_monitor_digital_gain_d = wr_cugain ?
    masked(reg_wdata, dc_loop_trim_pkg::MASK_GAIN) : current_monitor_digital_gain_q;
  wire [15:0] voltage_loop_hold_control_d = wr_ctrl ?
    masked(reg_wdata, dc_loop_trim_pkg::MASK_HOLD_CTRL) : voltage_loop_hold_control_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sense_amp_offset_q             <= dc_loop_trim_pkg::RST_SENSE_OFFSET;
      feedback_digital_gain_q        <= dc_loop_trim_pkg::RST_GAIN;
      current_monitor_digital_gain_q <= dc_loop_trim_pkg::RST_GAIN;
      voltage_loop_hold_control_q    <= dc_loop_trim_pkg::RST_HOLD_CTRL;
    end else begin
      sense_amp_offset_q             <= sense_amp_offset_d;
      feedback_digital_gain_q        <= feedback_digital_gain_d;
      current_monitor_digital_gain_q <= current_monitor_digital_gain_d;
      voltage_loop_hold_control_q    <= voltage_loop_hold_control_d;
    end
  end

  // Read mux; unmapped codes return zero
  logic [15:0] read_mux;
  always_comb begin
    unique case (reg_addr)
      dc_loop_trim_pkg::ADDR_SENSE_OFFSET: read_mux = sense_amp_offset_q;
      dc_loop_trim_pkg::ADDR_FB_GAIN:      read_mux = feedback_digital_gain_q;
      dc_loop_trim_pkg::ADDR_CUR_GAIN:     read_mux = current_monitor_digital_gain_q;
      dc_loop_trim_pkg::ADDR_HOLD_CTRL:    read_mux = voltage_loop_hold_control_q;
      default:                             read_mux = 16'h0000;
    endcase
  end

  // Field views
  wire [dc_loop_trim_pkg::OFFSET_W-1:0] sense_offset_value =
    sense_amp_offset_q[dc_loop_trim_pkg::OFFSET_W-1:0];
  wire [dc_loop_trim_pkg::GAIN_W-1:0] feedback_gain_value =
    feedback_digital_gain_q[dc_loop_trim_pkg::GAIN_W-1:0];
  wire [dc_loop_trim_pkg::GAIN_W-1:0] current_report_gain_value =
    current_monitor_digital_gain_q[dc_loop_trim_pkg::GAIN_W-1:0];
  wire freq_phase_add_idle_level      = voltage_loop_hold_control_q[dc_loop_trim_pkg::FREQ_IDLE_BIT];
  wire undervolt_phase_add_idle_level = voltage_loop_hold_control_q[dc_loop_trim_pkg::UV_IDLE_BIT];
  wire [dc_loop_trim_pkg::PRD_THR_W-1:0] period_error_threshold =
    voltage_loop_hold_control_q[dc_loop_trim_pkg::PRD_THR_MSB:dc_loop_trim_pkg::PRD_THR_LSB];
  wire period_error_hold_enable = voltage_loop_hold_control_q[dc_loop_trim_pkg::PRD_HOLD_BIT];
  wire phase_change_hold_enable = voltage_loop_hold_control_q[dc_loop_trim_pkg::PHASE_HOLD_BIT];
  wire excursion_hold_enable    = voltage_loop_hold_control_q[dc_loop_trim_pkg::EXC_HOLD_BIT];
  wire [dc_loop_trim_pkg::HOLD_LEN_W-1:0] voltage_loop_hold_length =
    voltage_loop_hold_control_q[dc_loop_trim_pkg::HOLD_LEN_MSB:dc_loop_trim_pkg::HOLD_LEN_LSB];

  // Offset: sign extend, then weight by the step of the selected sense gain
  wire signed [7:0] offset_signed =
    {sense_offset_value[dc_loop_trim_pkg::OFFSET_SIGN_BIT], sense_offset_value};
  wire [4:0] step_100uv = sense_amp_gain_select ? STEP_HALF : STEP_UNITY;
  wire signed [17:0] offset_uv_d = 18'(offset_signed * $signed({1'b0, step_100uv}) * 18'sd100);
  wire signed [SENSE_W+1:0] corrected_sum = $signed({2'b00, sensed_output_uv}) + (SENSE_W+2)'(offset_uv_d);
  // Clamp so a negative offset on a tiny reading cannot wrap to full scale
  wire [SENSE_W-1:0] corrected_d = corrected_sum[SENSE_W+1] ? '0 :
    (corrected_sum[SENSE_W] ? '1 : corrected_sum[SENSE_W-1:0]);

  // Feedback excursion window
  wire signed [VOLT_W:0] fb_error = $signed({1'b0, feedback_voltage}) - $signed({1'b0, output_reference});
  wire fb_under = fb_error < -UNDER_LIM;
  wire fb_over  = fb_error > OVER_LIM;

  // Period deviation compared in ns
  wire [PERIOD_W:0] prd_dev     = distance(measured_period_ns, configured_period_ns);
  wire [PERIOD_W:0] prd_limit   = (PERIOD_W+1)'({{(PERIOD_W+1-dc_loop_trim_pkg::PRD_THR_W){1'b0}},
                                    period_error_threshold} * PRD_STEP);
  wire              prd_error_d = prd_dev > prd_limit;

  // Phase add decision; undervoltage wins the idle level when both fire
  wire ccm_d  = auto_shed_mode && (freq_over_limit || fb_under);
  wire idle_d = fb_under ? undervolt_phase_add_idle_level : freq_phase_add_idle_level;

  // Hold triggers
  logic [PHASE_W-1:0] phase_count_q;
  logic               phase_seen_q;
  wire phase_changed = phase_seen_q && (active_phase_count != phase_count_q);
  wire trig_period   = period_error_hold_enable && period_hold_qualify && prd_error_d;
  wire trig_phase    = phase_change_hold_enable && phase_changed;
  wire trig_exc      = excursion_hold_enable && (fb_under || fb_over);
  wire trigger       = trig_period || trig_phase || trig_exc;

  // Hold timer: divider gives one pulse per 100 us step
  hold_state_t                          state_q;
  hold_state_t                          state_d;
  logic [HDIV_W-1:0]                    div_q;
  logic [dc_loop_trim_pkg::HOLD_LEN_W-1:0] steps_q;
  wire step_pulse = (state_q == HOLD_FROZEN) && (div_q == HDIV_LAST);
  wire expire     = step_pulse && (steps_q <= 4'd1);
  wire zero_len   = (voltage_loop_hold_length == '0);
  // Hold shows at once on a trigger, even with a zero length
  wire hold_d     = trigger || (state_d == HOLD_FROZEN);

  always_comb begin
    unique case (state_q)
      HOLD_IDLE:   state_d = (trigger && !zero_len) ? HOLD_FROZEN : HOLD_IDLE;
      // A zero length retrigger drops back to trigger-only holding
      HOLD_FROZEN: state_d = ((expire && !trigger) || (trigger && zero_len)) ? HOLD_IDLE : HOLD_FROZEN;
      default:     state_d = HOLD_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= HOLD_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      div_q   <= '0;
      steps_q <= '0;
    end else begin
      if (trigger) begin
        div_q   <= '0;
        steps_q <= voltage_loop_hold_length;
      end else if (state_q == HOLD_FROZEN) begin
        div_q   <= step_pulse ? '0 : div_q + 1'b1;
        steps_q <= step_pulse ? steps_q - 1'b1 : steps_q;
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_count_q <= '0;
      phase_seen_q  <= 1'b0;
    end else begin
      phase_count_q <= active_phase_count;
      phase_seen_q  <= 1'b1;
    end
  end

  // Registered outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= read_mux;
    end
  end

  // Sense path results
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sense_offset_uv    <= '0;
      sense_corrected_uv <= '0;
    end else begin
      sense_offset_uv    <= offset_uv_d;
      sense_corrected_uv <= corrected_d;
    end
  end

  // Phase add and hold results
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      full_phase_ccm    <= 1'b0;
      idle_phase_level  <= 1'b0;
      period_error      <= 1'b0;
      voltage_loop_hold <= 1'b0;
    end else begin
      full_phase_ccm    <= ccm_d;
      idle_phase_level  <= idle_d;
      period_error      <= prd_error_d;
      voltage_loop_hold <= hold_d;
    end
  end

  sample_gain_scaler #(
    .RAW_W  (ADC_W),
    .GAIN_W (dc_loop_trim_pkg::GAIN_W),
    .FRAC   (dc_loop_trim_pkg::GAIN_FRAC)
  ) u_feedback_scaler (
    .clock  (clock),
    .arst_n (arst_n),
    .raw    (feedback_raw_sample),
    .gain   (feedback_gain_value),
    .scaled (feedback_scaled_sample)
  );

  sample_gain_scaler #(
    .RAW_W  (ADC_W),
    .GAIN_W (dc_loop_trim_pkg::GAIN_W),
    .FRAC   (dc_loop_trim_pkg::GAIN_FRAC)
  ) u_current_scaler (
    .clock  (clock),
    .arst_n (arst_n),
    .raw    (current_raw_sample),
    .gain   (current_report_gain_value),
    .scaled (current_scaled_sample)
  );

endmodule // dc_loop_trim_and_hold_ctrl

// [sim/dc_loop_trim_checker.sv]
`timescale 1ns/10ps
module dc_loop_trim_checker #(
  parameter int VOLT_W   = 16,
  parameter int PERIOD_W = 16,
  parameter int PHASE_W  = 3,
  parameter int SENSE_W  = 22
) (
  input wire logic                clock,
  input wire logic                arst_n,
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr,
  input wire logic [15:0]         reg_wdata,
  input wire logic [15:0]         reg_rdata,
  input wire logic                sense_amp_gain_select,
  input wire logic [SENSE_W-1:0]  sensed_output_uv,
  input wire logic [SENSE_W-1:0]  sense_corrected_uv,
  input wire logic signed [17:0]  sense_offset_uv,
  input wire logic                auto_shed_mode,
  input wire logic                freq_over_limit,
  input wire logic [VOLT_W-1:0]   feedback_voltage,
  input wire logic [VOLT_W-1:0]   output_reference,
  input wire logic                full_phase_ccm,
  input wire logic                idle_phase_level,
  input wire logic [PERIOD_W-1:0] measured_period_ns,
  input wire logic [PERIOD_W-1:0] configured_period_ns,
  input wire logic                period_hold_qualify,
  input wire logic [PHASE_W-1:0]  active_phase_count,
  input wire logic                period_error,
  input wire logic                voltage_loop_hold
);
  logic [15:0]        ctrl_q;
  logic [15:0]        since_q;
  logic [PHASE_W-1:0] phase_q;
  logic [SENSE_W-1:0] sensed_q;
  logic               armed_q;
  wire signed [31:0] fb_diff = 32'(feedback_voltage) - 32'(output_reference);
  wire under = fb_diff < -100;
  wire over = fb_diff > 80;
  wire [31:0] dev = (measured_period_ns > configured_period_ns) ? 32'(measured_period_ns - configured_period_ns)
                                                                : 32'(configured_period_ns - measured_period_ns);
  wire perr = dev > 32'(ctrl_q[13:7]) * 80;
  wire trig = (ctrl_q[6] & period_hold_qualify & perr) | (ctrl_q[4] & (under | over))
            | (ctrl_q[5] & armed_q & (active_phase_count != phase_q));
  wire [31:0] hold_cyc = 32'(ctrl_q[3:0]) * 32'(dc_loop_trim_pkg::HOLD_STEP_CYCLES);
  wire signed [31:0] sum = 32'(sensed_q) + 32'(sense_offset_uv);
  wire [SENSE_W-1:0] corr = (sum < 0) ? '0 : (sum > (1 << SENSE_W) - 1) ? '1 : sum[SENSE_W-1:0];
  // Shadow of the hold register and time since the last hold cause
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= '0;
      since_q <= '1;
      phase_q <= '0;
      sensed_q <= '0;
      armed_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == dc_loop_trim_pkg::ADDR_HOLD_CTRL) ctrl_q <= reg_wdata;
      since_q <= trig ? 16'h0000 : (since_q == 16'hffff) ? since_q : since_q + 16'h0001;
      phase_q <= active_phase_count;
      sensed_q <= sensed_output_uv;
      armed_q <= 1'b1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_offset_reserved_zero: assert property (reg_addr == 8'h2d |=> reg_rdata[15:7] == 9'h000)
    else $error("offset register upper bits not zero");
  a_gain_reserved_zero: assert property (reg_addr inside {8'h2e, 8'h2f} |=> reg_rdata[15:11] == 5'h00)
    else $error("gain register upper bits not zero");
  a_corrected_sum: assert property (sense_corrected_uv == corr)
    else $error("corrected sense value wrong");
  a_unity_weight: assert property (!sense_amp_gain_select |=> sense_offset_uv % 500 == 0)
    else $error("offset weight at unity gain wrong");
  a_half_weight: assert property (sense_amp_gain_select |=> sense_offset_uv % 800 == 0)
    else $error("offset weight at half gain wrong");
  a_ccm_cause: assert property (1'b1 |=> full_phase_ccm == $past(auto_shed_mode && (freq_over_limit || under)))
    else $error("full phase mode wrong");
  a_idle_level: assert property (1'b1 |=> idle_phase_level == $past(under ? ctrl_q[14] : ctrl_q[15]))
    else $error("idle phase level wrong");
  a_period_flag: assert property (1'b1 |=> period_error == $past(perr))
    else $error("period error flag wrong");
  a_hold_start: assert property (trig |=> voltage_loop_hold)
    else $error("hold did not start");
  a_hold_expires: assert property (voltage_loop_hold |-> 32'(since_q) <= hold_cyc + 2)
    else $error("hold lasted too long");
  a_hold_stays: assert property (since_q != 16'hffff && 32'(since_q) + 2 < hold_cyc |-> voltage_loop_hold)
    else $error("hold ended too early");
  c_trig: cover property (trig);
  c_ccm: cover property (full_phase_ccm && idle_phase_level);
  c_perr: cover property (period_error);
endmodule // dc_loop_trim_checker

bind dc_loop_trim_and_hold_ctrl dc_loop_trim_checker #(
  .VOLT_W(VOLT_W), .PERIOD_W(PERIOD_W), .PHASE_W(PHASE_W), .SENSE_W(SENSE_W)
) i_chk (
  .clock, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .sense_amp_gain_select, .sensed_output_uv,
  .sense_corrected_uv, .sense_offset_uv, .auto_shed_mode, .freq_over_limit, .feedback_voltage, .output_reference,
  .full_phase_ccm, .idle_phase_level, .measured_period_ns, .configured_period_ns, .period_hold_qualify,
  .active_phase_count, .period_error, .voltage_loop_hold
);

// [sim/testbench.sv]
`timescale 1ns/10ps
module testbench;
  logic clock, arst_n, reg_wr, sense_amp_gain_select, auto_shed_mode, freq_over_limit, period_hold_qualify;
  logic [7:0]         reg_addr;
  logic [15:0]        reg_wdata, reg_rdata, feedback_voltage, output_reference;
  logic [15:0]        measured_period_ns, configured_period_ns;
  logic [21:0]        sensed_output_uv, sense_corrected_uv;
  logic signed [17:0] sense_offset_uv;
  logic [11:0]        feedback_raw_sample, current_raw_sample;
  logic [12:0]        feedback_scaled_sample, current_scaled_sample;
  logic [2:0]         active_phase_count;
  logic               full_phase_ccm, idle_phase_level, period_error, voltage_loop_hold;
  logic [15:0]        msk [4] = '{16'h007f, 16'h07ff, 16'h07ff, 16'hffff};
  int                 n_fail, samples_checked, cyc;

  dc_loop_trim_and_hold_ctrl i_dut (
    .clock, .arst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .sense_amp_gain_select, .sensed_output_uv,
    .sense_corrected_uv, .sense_offset_uv, .feedback_raw_sample, .current_raw_sample, .feedback_scaled_sample,
    .current_scaled_sample, .auto_shed_mode, .freq_over_limit, .feedback_voltage, .output_reference,
    .full_phase_ccm, .idle_phase_level, .measured_period_ns, .configured_period_ns, .period_hold_qualify,
    .active_phase_count, .period_error, .voltage_loop_hold
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wr <= 1'b1;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    tick(2);
    chk(24'(reg_rdata), 24'(e));
  endtask
  task test_done;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Whole run needs about 7400 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end

  initial begin
    {arst_n, reg_wr, sense_amp_gain_select, auto_shed_mode, freq_over_limit, period_hold_qualify} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    sensed_output_uv = 22'h01_86a0;
    feedback_raw_sample = 12'h3e8;
    current_raw_sample = 12'h3e8;
    feedback_voltage = 16'h0fa0;
    output_reference = 16'h0fa0;
    measured_period_ns = 16'h03e8;
    configured_period_ns = 16'h03e8;
    active_phase_count = 3'h2;
    repeat (20) @(posedge clock);
    arst_n <= 1'b1;
    rd(8'h2d, 16'h0000);
    rd(8'h2e, 16'h0400);
    rd(8'h2f, 16'h0400);
    rd(8'h30, 16'h0000);
    rd(8'h31, 16'h0000);
    chk(24'(feedback_scaled_sample), 24'h00_03e8);
    chk(24'(current_scaled_sample), 24'h00_03e8);
    for (int i = 0; i < 4; i++) begin
      wr(8'h2d + 8'(i), 16'hffff);
      rd(8'h2d + 8'(i), msk[i]);
    end
    wr(8'h2e, 16'hf200);
    tick(2);
    chk(24'(feedback_scaled_sample), 24'h00_01f4);
    chk(24'(current_scaled_sample), 24'h00_07cf);
    $display("test registers and gains done");
    // Bit 7 dropped leaves -64
    wr(8'h2d, 16'h00c0);
    tick(2);
    chk(24'(sense_offset_uv), 24'hff_8300);
    chk(24'(sense_corrected_uv), 24'h01_09a0);
    @(posedge clock);
    sense_amp_gain_select <= 1'b1;
    sensed_output_uv <= 22'h00_2710;
    tick(2);
    chk(24'(sense_offset_uv), 24'hff_3800);
    chk(24'(sense_corrected_uv), 24'h00_0000);
    wr(8'h2d, 16'h003f);
    sensed_output_uv <= 22'h3f_ffff;
    tick(2);
    chk(24'(sense_offset_uv), 24'h00_c4e0);
    chk(24'(sense_corrected_uv), 24'h3f_ffff);
    $display("test sense offset done");
    wr(8'h30, 16'h8000);
    auto_shed_mode <= 1'b1;
    freq_over_limit <= 1'b1;
    tick(2);
    chk(24'(full_phase_ccm), 24'h00_0001);
    chk(24'(idle_phase_level), 24'h00_0001);
    @(posedge clock);
    freq_over_limit <= 1'b0;
    feedback_voltage <= 16'h0f3b;
    tick(2);
    chk(24'(full_phase_ccm), 24'h00_0001);
    chk(24'(idle_phase_level), 24'h00_0000);
    chk(24'(voltage_loop_hold), 24'h00_0000);
    @(posedge clock);
    auto_shed_mode <= 1'b0;
    tick(2);
    chk(24'(full_phase_ccm), 24'h00_0000);
    $display("test phase adding done");
    // Threshold 2 steps is 160 ns
    wr(8'h30, 16'h0100);
    feedback_voltage <= 16'h0fa0;
    period_hold_qualify <= 1'b1;
    measured_period_ns <= 16'h0488;
    tick(2);
    chk(24'(period_error), 24'h00_0000);
    @(posedge clock);
    measured_period_ns <= 16'h0489;
    tick(2);
    chk(24'(period_error), 24'h00_0001);
    @(posedge clock);
    measured_period_ns <= 16'h0347;
    tick(2);
    chk(24'(period_error), 24'h00_0001);
    chk(24'(voltage_loop_hold), 24'h00_0000);
    $display("test period error done");
    wr(8'h30, 16'h0011);
    measured_period_ns <= 16'h03e8;
    feedback_voltage <= 16'h0ff1;
    @(posedge clock);
    feedback_voltage <= 16'h0fa0;
    tick(1000);
    chk(24'(voltage_loop_hold), 24'h00_0001);
    tick(1100);
    chk(24'(voltage_loop_hold), 24'h00_0000);
    wr(8'h30, 16'h0021);
    active_phase_count <= 3'h3;
    tick(1000);
    chk(24'(voltage_loop_hold), 24'h00_0001);
    @(posedge clock);
    active_phase_count <= 3'h2;
    tick(1500);
    chk(24'(voltage_loop_hold), 24'h00_0001);
    tick(600);
    chk(24'(voltage_loop_hold), 24'h00_0000);
    // Threshold 0, so a 1 ns deviation counts
    wr(8'h30, 16'h0041);
    measured_period_ns <= 16'h03e9;
    @(posedge clock);
    measured_period_ns <= 16'h03e8;
    tick(1000);
    chk(24'(voltage_loop_hold), 24'h00_0001);
    tick(1100);
    @(posedge clock);
    period_hold_qualify <= 1'b0;
    measured_period_ns <= 16'h03e9;
    tick(3);
    chk(24'(voltage_loop_hold), 24'h00_0000);
    $display("test loop hold done");
    test_done;
  end
endmodule // testbench
